// ---- logic/bcse_pkg.sv ----
// Purpose: shared constants for the bus cycle status encoder
// Assumes: status pins are active low; qualifiers are active high codes
// Notes:   cycle kinds are one-hot coded requests from the core
package bcse_pkg;

  // ---------------------------------------------------------------------
  // cycle kinds requested by the core
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    BCSE_KIND_INTA  = 3'h1,   // interrupt acknowledge
    BCSE_KIND_HALT  = 3'h2,   // halt
    BCSE_KIND_SHUT  = 3'h4    // shutdown
  } bcse_kind_t;

  // ---------------------------------------------------------------------
  // encoder states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    BCSE_ST_IDLE   = 3'h1,    // no status cycle
    BCSE_ST_STATUS = 3'h2,    // send_status_state
    BCSE_ST_HOLD   = 3'h4     // bus hold acknowledge, pins released
  } bcse_state_t;

  // ---------------------------------------------------------------------
  // pin codes {cod_int, m_io, hi_n, lo_n}
  // ---------------------------------------------------------------------
  localparam logic [3:0] BCSE_CODE_INTA = 4'h0;  // all low
  localparam logic [3:0] BCSE_CODE_NONE = 4'h3;  // no status cycle
  localparam logic [3:0] BCSE_CODE_HALT = 4'h4;  // m_io high, pins low
  localparam logic [1:0] BCSE_STAT_IDLE = 2'h3;  // both status pins high
  localparam logic [3:0] BCSE_RESET_CODE = 4'h3; // value after reset
  localparam logic       BCSE_ADDR1_HALT = 1'b1; // address_bit_one halt
  localparam logic       BCSE_ADDR1_SHUT = 1'b0; // address_bit_one shutdown

endpackage

// ---- logic/bcse_pin_drv.sv ----
// Purpose: four-signal driver for one active-low status pin
// Assumes: the wire reads high when released (pull-up outside)
// Notes:   output enable high while this module drives the pin
`timescale 1ns/10ps

module bcse_pin_drv (
  input  wire logic release_pin,  // high during bus hold acknowledge
  input  wire logic level_q,      // registered level to present
  output logic      pin_o,        // pin output value
  output logic      pin_oe        // pin output enable
);

  // ---------------------------------------------------------------------
  // drive unless released; released pin floats to logic one
  // ---------------------------------------------------------------------
  assign pin_oe = ~release_pin;
  assign pin_o  = release_pin ? 1'b1 : level_q;

endmodule // bcse_pin_drv

// ---- logic/bcse_encoder.sv ----
// Purpose: encode bus cycle type onto status pins and qualifiers
// Assumes: start request is a one-cycle pulse synchronous to ref_clk
// Notes:   status held one cycle per request, then back to idle code
`timescale 1ns/10ps

module bcse_encoder (
  input  wire logic        ref_clk,            // 10 MHz clock
  input  wire logic        reset,              // sync reset, active high
  input  wire logic        cycle_start,        // pulse: begin a cycle
  input  wire logic [2:0]  cycle_kind,         // one-hot kind of cycle
  input  wire logic        hold_ack,           // bus hold acknowledge
  output logic             cycle_status_hi_n_o,  // status hi pin out
  output logic             cycle_status_hi_n_oe, // status hi pin enable
  output logic             cycle_status_lo_n_o,  // status lo pin out
  output logic             cycle_status_lo_n_oe, // status lo pin enable
  output logic             cod_int_q,          // code-or-interrupt
  output logic             m_io_q,             // memory-or-IO
  output logic             address_bit_one_q,  // halt vs shutdown
  output logic             send_status_state   // status phase active
);

  bcse_pkg::bcse_state_t state_q;
  bcse_pkg::bcse_state_t state_d;
  logic [3:0]            code_q;
  logic                  start_ok;

  // ---------------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------------
  // only one-hot kinds start a cycle; anything else is dropped so no
  // undefined code can reach the pins
  function automatic logic kind_legal(input logic [2:0] k);
    kind_legal = (k == bcse_pkg::BCSE_KIND_INTA) ||
                 (k == bcse_pkg::BCSE_KIND_HALT) ||
                 (k == bcse_pkg::BCSE_KIND_SHUT);
  endfunction

  assign start_ok = cycle_start & kind_legal(cycle_kind) & ~hold_ack;

  // ---------------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bcse_pkg::BCSE_ST_IDLE: begin
        if (hold_ack) begin
          state_d = bcse_pkg::BCSE_ST_HOLD;
        end else if (start_ok) begin
          state_d = bcse_pkg::BCSE_ST_STATUS;
        end
      end
      bcse_pkg::BCSE_ST_STATUS: begin
        // status lasts a single clock unless a new request arrives, then the code returns to none
        if (hold_ack) begin
          state_d = bcse_pkg::BCSE_ST_HOLD;
        end else if (start_ok) begin
          state_d = bcse_pkg::BCSE_ST_STATUS;
        end else begin
          state_d = bcse_pkg::BCSE_ST_IDLE;
        end
      end
      bcse_pkg::BCSE_ST_HOLD: begin
        if (!hold_ack) begin
          state_d = bcse_pkg::BCSE_ST_IDLE;
        end
      end
      default: state_d = bcse_pkg::BCSE_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= bcse_pkg::BCSE_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------
  // code register {cod_int, m_io, hi_n, lo_n}
  // ---------------------------------------------------------------------
  // only the three legal codes are ever loaded, so the reserved pair
  // with a single low status pin cannot appear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      code_q <= bcse_pkg::BCSE_RESET_CODE;
    end else if (state_d == bcse_pkg::BCSE_ST_STATUS && start_ok) begin
      if (cycle_kind == bcse_pkg::BCSE_KIND_INTA) begin
        code_q <= bcse_pkg::BCSE_CODE_INTA;
      end else begin
        code_q <= bcse_pkg::BCSE_CODE_HALT;
      end
    end else begin
      code_q <= bcse_pkg::BCSE_CODE_NONE;
    end
  end

  // halt/shutdown discriminator on address_bit_one
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      address_bit_one_q <= bcse_pkg::BCSE_ADDR1_SHUT;
    end else if (start_ok &&
                 cycle_kind == bcse_pkg::BCSE_KIND_HALT) begin
      address_bit_one_q <= bcse_pkg::BCSE_ADDR1_HALT;
    end else if (start_ok &&
                 cycle_kind == bcse_pkg::BCSE_KIND_SHUT) begin
      address_bit_one_q <= bcse_pkg::BCSE_ADDR1_SHUT;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign cod_int_q = code_q[3];
  assign m_io_q    = code_q[2];
  // status phase is exactly when a status pin is driven low
  assign send_status_state = (state_q == bcse_pkg::BCSE_ST_STATUS);

  // pins released while hold is granted
  bcse_pin_drv u_hi (
    .release_pin (state_q == bcse_pkg::BCSE_ST_HOLD),
    .level_q     (code_q[1]),
    .pin_o       (cycle_status_hi_n_o),
    .pin_oe      (cycle_status_hi_n_oe)
  );

  bcse_pin_drv u_lo (
    .release_pin (state_q == bcse_pkg::BCSE_ST_HOLD),
    .level_q     (code_q[0]),
    .pin_o       (cycle_status_lo_n_o),
    .pin_oe      (cycle_status_lo_n_oe)
  );

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  chk_status_low_tie: assert property (
    @(posedge ref_clk) disable iff (reset)
    send_status_state == (!cycle_status_hi_n_o || !cycle_status_lo_n_o))
    else $error("send status state does not match status pins");

  chk_hold_release: assert property (
    @(posedge ref_clk) disable iff (reset)
    $past(hold_ack) && hold_ack |-> !cycle_status_hi_n_oe &&
      !cycle_status_lo_n_oe && cycle_status_hi_n_o && cycle_status_lo_n_o)
    else $error("status pins driven during hold acknowledge");

  chk_inta_code: assert property (
    @(posedge ref_clk) disable iff (reset)
    start_ok && cycle_kind == bcse_pkg::BCSE_KIND_INTA |=> !cod_int_q &&
      !m_io_q && !cycle_status_hi_n_o && !cycle_status_lo_n_o)
    else $error("interrupt acknowledge code wrong");

  chk_idle_none: assert property (
    @(posedge ref_clk) disable iff (reset)
    !$past(start_ok) && !hold_ack && !$past(hold_ack) |->
      cycle_status_hi_n_o && cycle_status_lo_n_o && !send_status_state)
    else $error("status shown without a request");

  chk_halt_addr: assert property (
    @(posedge ref_clk) disable iff (reset)
    start_ok && cycle_kind == bcse_pkg::BCSE_KIND_HALT |=>
      address_bit_one_q && m_io_q && !cod_int_q &&
      !cycle_status_hi_n_o && !cycle_status_lo_n_o)
    else $error("halt not flagged on address bit one");

  chk_shut_addr: assert property (
    @(posedge ref_clk) disable iff (reset)
    start_ok && cycle_kind == bcse_pkg::BCSE_KIND_SHUT |=>
      !address_bit_one_q && send_status_state)
    else $error("shutdown not flagged on address bit one");

  chk_no_reserved: assert property (
    @(posedge ref_clk) disable iff (reset)
    !cod_int_q && !m_io_q && cycle_status_hi_n_oe &&
      cycle_status_lo_n_oe |->
      !(cycle_status_hi_n_o ^ cycle_status_lo_n_o))
    else $error("reserved status code emitted");

  chk_status_one: assert property (
    @(posedge ref_clk) disable iff (reset)
    send_status_state && !start_ok && !hold_ack |=> !send_status_state)
    else $error("status phase longer than one cycle");

  chk_hold_entry: assert property (
    @(posedge ref_clk) disable iff (reset)
    hold_ack |=> !cycle_status_hi_n_oe && !cycle_status_lo_n_oe &&
      cycle_status_hi_n_o && cycle_status_lo_n_o)
    else $error("status pins not released on hold acknowledge");

  chk_unhold_drive: assert property (
    @(posedge ref_clk) disable iff (reset)
    !hold_ack |=> cycle_status_hi_n_oe && cycle_status_lo_n_oe)
    else $error("status pins not driven after hold ends");

  chk_none_after: assert property (
    @(posedge ref_clk) disable iff (reset)
    send_status_state && !start_ok |=> cycle_status_hi_n_o &&
      cycle_status_lo_n_o && !cod_int_q && !m_io_q)
    else $error("none code not shown after status clock");

  chk_addr_stands: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(start_ok && (cycle_kind == bcse_pkg::BCSE_KIND_HALT ||
      cycle_kind == bcse_pkg::BCSE_KIND_SHUT)) |=>
      $stable(address_bit_one_q))
    else $error("address bit one changed without a request");

  chk_illegal_kind: assert property (
    @(posedge ref_clk) disable iff (reset)
    cycle_start && !kind_legal(cycle_kind) && !hold_ack |=>
      !send_status_state)
    else $error("status shown for an illegal kind");

endmodule // bcse_encoder

// ---- bench/bcse_ctrl_model.sv ----
// Purpose: bus controller model that decodes the status pins
// Assumes: pull-ups hold released status pins high
// Notes:   reserved codes start nothing; they are only remembered
`timescale 1ns/10ps

module bcse_ctrl_model (
  input  wire logic ref_clk,   // clock
  input  wire logic hi_o,      // status hi pin value
  input  wire logic hi_oe,     // status hi pin enable
  input  wire logic lo_o,      // status lo pin value
  input  wire logic lo_oe,     // status lo pin enable
  input  wire logic cod_int,   // code-or-interrupt
  input  wire logic m_io,      // memory-or-IO
  output logic      hi_w,      // resolved hi wire
  output logic      lo_w,      // resolved lo wire
  output logic      cmd_go,    // command starts this cycle
  output logic      rsvd_seen  // sticky: reserved code seen
);
  // the pull-up wins whenever a pin is released
  assign hi_w = hi_oe ? hi_o : 1'b1;
  assign lo_w = lo_oe ? lo_o : 1'b1;
  // a low status pin starts a command unless the code is reserved; the none code starts nothing
  assign cmd_go = !(hi_w && lo_w) &&
                  (cod_int || m_io || !(hi_w ^ lo_w));
  initial rsvd_seen = 1'b0;
  // ignored by the controller, kept only so the bench can see it
  always @(posedge ref_clk)
    if (!cod_int && !m_io && (hi_w ^ lo_w)) rsvd_seen <= 1'b1;
endmodule // bcse_ctrl_model

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the bus cycle status encoder
// Assumes: inputs change at the falling edge, outputs sampled there
// Notes:   one task per scenario
`timescale 1ns/10ps

module tb;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       cycle_start = 1'b0;
  logic       hold_ack = 1'b0;
  logic [2:0] cycle_kind = 3'h0;
  logic       hi_o, hi_oe, lo_o, lo_oe, cod, mio, a1, sss;
  logic       hi_w, lo_w, go, rsvd;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  always #50 ref_clk = ~ref_clk;

  bcse_encoder u_dut (.ref_clk(ref_clk), .reset(reset),
    .cycle_start(cycle_start), .cycle_kind(cycle_kind),
    .hold_ack(hold_ack), .cycle_status_hi_n_o(hi_o),
    .cycle_status_hi_n_oe(hi_oe), .cycle_status_lo_n_o(lo_o),
    .cycle_status_lo_n_oe(lo_oe), .cod_int_q(cod), .m_io_q(mio),
    .address_bit_one_q(a1), .send_status_state(sss));
  bcse_ctrl_model u_ctrl (.ref_clk(ref_clk), .hi_o(hi_o), .hi_oe(hi_oe),
    .lo_o(lo_o), .lo_oe(lo_oe), .cod_int(cod), .m_io(mio), .hi_w(hi_w),
    .lo_w(lo_w), .cmd_go(go), .rsvd_seen(rsvd));

  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // raise a request for one edge, then drop it at the next falling edge
  task automatic req(logic [2:0] k);
    @(negedge ref_clk);
    cycle_start = 1'b1;
    cycle_kind = k;
    @(negedge ref_clk);
    cycle_start = 1'b0;
    cycle_kind = 3'h0;
  endtask

  // the none code: qualifiers low, both pins high, no command
  task automatic t_none(string nm);
    chk({nm, " code"}, {cod, mio, hi_w, lo_w}, 4'h3);
    chk({nm, " go"}, {3'h0, go | sss}, 4'h0);
  endtask

  task automatic t_inta;
    req(3'h1);
    chk("inta code", {cod, mio, hi_w, lo_w}, 4'h0);
    chk("inta tss", {2'h0, go, sss}, 4'h3);
    @(negedge ref_clk);
    t_none("after inta");
  endtask

  // halt and shutdown differ only in address_bit_one
  task automatic t_halt(logic [2:0] k, logic bit1);
    req(k);
    chk("halt code", {cod, mio, hi_w, lo_w}, 4'h4);
    chk("halt a1", {3'h0, a1}, {3'h0, bit1});
    chk("halt tss", {2'h0, go, sss}, 4'h3);
    @(negedge ref_clk);
    chk("a1 stands", {3'h0, a1}, {3'h0, bit1});
    t_none("after halt");
  endtask

  // hold wins over a request made in the same cycle
  task automatic t_hold;
    @(negedge ref_clk);
    hold_ack = 1'b1;
    cycle_start = 1'b1;
    cycle_kind = 3'h1;
    @(negedge ref_clk);
    chk("hold oe", {2'h0, hi_oe, lo_oe}, 4'h0);
    chk("hold wire", {1'b0, go, hi_w, lo_w}, 4'h3);
    @(negedge ref_clk);
    cycle_start = 1'b0;
    cycle_kind = 3'h0;
    chk("hold long", {1'b0, hi_oe, lo_oe, sss}, 4'h0);
    hold_ack = 1'b0;
    @(negedge ref_clk);
    chk("unhold oe", {2'h0, hi_oe, lo_oe}, 4'h3);
    t_none("unhold");
  endtask

  // back to back: a shutdown request made in the inta status clock
  task automatic t_b2b;
    @(negedge ref_clk);
    cycle_start = 1'b1;
    cycle_kind = 3'h1;
    @(negedge ref_clk);
    cycle_kind = 3'h4;
    chk("b2b inta", {cod, mio, hi_w, lo_w}, 4'h0);
    @(negedge ref_clk);
    cycle_start = 1'b0;
    cycle_kind = 3'h0;
    chk("b2b shut", {cod, mio, hi_w, lo_w}, 4'h4);
    chk("b2b a1", {3'h0, a1}, 4'h0);
    @(negedge ref_clk);
    t_none("after b2b");
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    t_none("reset");
    chk("reset oe", {1'b0, a1, hi_oe, lo_oe}, 4'h3);
    t_inta();
    t_halt(3'h2, 1'b1);
    t_halt(3'h4, 1'b0);
    t_halt(3'h2, 1'b1);
    t_b2b();
    t_hold();
    req(3'h3);
    t_none("bad kind");
    chk("reserved", {3'h0, rsvd}, 4'h0);
    close_out();
  end
endmodule // tb
